// ### hw/clmon_pkg.sv
// shared constants for the control-loop debug monitor register bank
`default_nettype none

package clmon_pkg;

   // apb address width in bits
   localparam int unsigned CLMON_ADDR_W = 12;

   // register indices; byte address is four times the index
   localparam logic [7:0]  CLMON_CUR_IDX  = 8'hf0;
   localparam logic [7:0]  CLMON_SPD_IDX  = 8'hf2;
   localparam logic [7:0]  CLMON_MON_IDX  = 8'hf4;
   localparam logic [11:0] CLMON_CUR_ADDR = {2'h0, CLMON_CUR_IDX, 2'h0};
   localparam logic [11:0] CLMON_SPD_ADDR = {2'h0, CLMON_SPD_IDX, 2'h0};
   localparam logic [11:0] CLMON_MON_ADDR = {2'h0, CLMON_MON_IDX, 2'h0};

   // reset values
   localparam logic [31:0] CLMON_CUR_RST = 32'h0000_0000;
   localparam logic [31:0] CLMON_SPD_RST = 32'h0000_0000;
   localparam logic [31:0] CLMON_MON_RST = 32'h0011_0000;

   // gain word layout
   localparam int unsigned CLMON_GAIN_W  = 16;
   localparam int unsigned CLMON_KI_LSB  = 16;
   localparam int unsigned CLMON_KP_LSB  = 0;

   // monitor control word layout
   localparam int unsigned CLMON_PTR_LSB  = 0;
   localparam int unsigned CLMON_PTR_W    = 12;
   localparam int unsigned CLMON_POL_BIT  = 12;
   localparam int unsigned CLMON_FRAC_LSB = 13;
   localparam int unsigned CLMON_FRAC_W   = 4;
   localparam int unsigned CLMON_P2_LSB   = 17;
   localparam int unsigned CLMON_P2_W     = 4;
   localparam int unsigned CLMON_CTRL_W   = 21;

   // monitor datapath: variable is signed q15, one per-unit is 2^15
   localparam int unsigned        CLMON_VAR_W    = 16;
   localparam int unsigned        CLMON_FRAC_SH  = 3;
   localparam logic signed [39:0] CLMON_PU       = 40'sh80_00;
   localparam logic signed [39:0] CLMON_ENUM_MAX = 40'sh1f;
   localparam int unsigned        CLMON_CODE_W   = 12;
   localparam int unsigned        CLMON_CODE_LSB = 3;
   localparam logic [11:0]        CLMON_CODE_MAX = 12'hfff;
   localparam logic [11:0]        CLMON_CODE_MID = 12'h800;

endpackage : clmon_pkg

`default_nettype wire

// ### hw/clmon_regs.sv
// apb register bank for loop gain readback and monitor output one scaling
//
// Function
// - current loop integral gain in use reads in bits 31-16, read-only
// - current loop proportional gain in use reads in bits 15-0, read-only
// - speed loop integral gain in use reads in bits 31-16, read-only
// - speed loop proportional gain in use reads in bits 15-0, read-only
// - twelve-bit variable pointer in monitor control bits 11-0, read/write
// - nonzero fraction field N scales monitored variable by N/8
// - zero fraction field treats variable as enumeration, 31 at most
// - enumeration mode scales by two to the power field value
// - polarity clear gives bipolar output, -1pu bottom, +1pu top
// - polarity set gives unipolar output, 0pu bottom, 1pu top
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none

module clmon_regs
   import clmon_pkg::*;
(
   // clock and reset
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   // apb slave
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [clmon_pkg::CLMON_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                        pwdata,
   output logic                                    pready,
   output logic [31:0]                             prdata,
   output logic                                    pslverr,
   // gains in use by the control loops
   input  wire logic [clmon_pkg::CLMON_GAIN_W-1:0] active_current_integral_gain,
   input  wire logic [clmon_pkg::CLMON_GAIN_W-1:0] active_current_proportional_gain,
   input  wire logic [clmon_pkg::CLMON_GAIN_W-1:0] active_velocity_integral_gain,
   input  wire logic [clmon_pkg::CLMON_GAIN_W-1:0] active_velocity_proportional_gain,
   // monitored variable fetch
   output logic [clmon_pkg::CLMON_PTR_W-1:0]       monitor_one_variable_pointer,
   input  wire logic signed [clmon_pkg::CLMON_VAR_W-1:0] monitor_var_value,
   // monitor output code
   output logic [clmon_pkg::CLMON_CODE_W-1:0]      monitor_output_one
);
   import clmon_pkg::*;

   typedef struct packed {
      logic [CLMON_CTRL_W-1:0] ctrl;
      logic [31:0]             rdata;
      logic [CLMON_CODE_W-1:0] code;
   } clmon_state_t;

   clmon_state_t st_reg;
   clmon_state_t st_next;

   logic                    setup_ph;
   logic                    access_ph;
   logic                    hit_cur;
   logic                    hit_spd;
   logic                    hit_mon;
   logic [CLMON_FRAC_W-1:0] frac_n;
   logic [CLMON_P2_W-1:0]   pow_p;
   logic                    single_sided;
   logic signed [39:0]      var_x;
   logic signed [39:0]      enum_x;
   logic signed [39:0]      scaled;
   logic signed [39:0]      level;
   logic [CLMON_CODE_W-1:0] code_calc;

   // apb phase and address decode
   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign hit_cur   = (paddr == CLMON_CUR_ADDR);
   assign hit_spd   = (paddr == CLMON_SPD_ADDR);
   assign hit_mon   = (paddr == CLMON_MON_ADDR);

   // zero wait states; unmapped access answers with an error
   assign pready  = access_ph;
   assign pslverr = access_ph & ~(hit_cur | hit_spd | hit_mon);

   // control fields
   assign frac_n       = st_reg.ctrl[CLMON_FRAC_LSB +: CLMON_FRAC_W];
   assign pow_p        = st_reg.ctrl[CLMON_P2_LSB +: CLMON_P2_W];
   assign single_sided = st_reg.ctrl[CLMON_POL_BIT];

   // monitor scaling; wide signed math avoids overflow at 15/8 and 2^15
   always_comb begin
      var_x  = 40'(monitor_var_value);
      enum_x = 40'sh0;
      scaled = 40'sh0;
      if (frac_n != 4'h0) begin
         scaled = (var_x * $signed({36'h0, frac_n})) >>> CLMON_FRAC_SH;
      end else begin
         enum_x = var_x <<< pow_p;
         if (enum_x < 40'sh0) begin
            enum_x = 40'sh0;
         end else if (enum_x > CLMON_ENUM_MAX) begin
            enum_x = CLMON_ENUM_MAX;
         end
         scaled = (enum_x * CLMON_PU) / CLMON_ENUM_MAX;
      end
      // polarity: bipolar shifts -1pu..+1pu onto 0..1pu
      if (single_sided) begin
         level = scaled;
      end else begin
         level = (scaled + CLMON_PU) >>> 1;
      end
      // saturate into the output code range
      if (level < 40'sh0) begin
         code_calc = '0;
      end else if (level >= CLMON_PU) begin
         code_calc = CLMON_CODE_MAX;
      end else begin
         code_calc = level[CLMON_CODE_LSB +: CLMON_CODE_W];
      end
   end

   // next state: register writes, read capture, output code
   always_comb begin
      st_next      = st_reg;
      st_next.code = code_calc;
      // read data captured in setup so prdata is a flop in the access phase
      if (setup_ph && !pwrite) begin
         if (hit_cur) begin
            st_next.rdata = {active_current_integral_gain,
                             active_current_proportional_gain};
         end else if (hit_spd) begin
            st_next.rdata = {active_velocity_integral_gain,
                             active_velocity_proportional_gain};
         end else if (hit_mon) begin
            st_next.rdata = {11'h0, st_reg.ctrl};
         end else begin
            st_next.rdata = 32'h0;
         end
      end
      // only the monitor word is writable; gain words ignore writes
      if (access_ph && pwrite && hit_mon) begin
         st_next.ctrl = pwdata[CLMON_CTRL_W-1:0];
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg.ctrl  <= CLMON_MON_RST[CLMON_CTRL_W-1:0];
         st_reg.rdata <= 32'h0;
         st_reg.code  <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flops
   assign prdata                       = st_reg.rdata;
   assign monitor_output_one           = st_reg.code;
   assign monitor_one_variable_pointer = st_reg.ctrl[CLMON_PTR_LSB +: CLMON_PTR_W];

   // assertions on readback, control writes and monitor scaling
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // a read setup followed by its access phase
   sequence s_read(logic hit);
      psel && !penable && !pwrite && hit ##1 psel && penable;
   endsequence

   // a completed write access
   sequence s_write(logic hit);
      psel && !penable && pwrite && hit ##1 psel && penable && pwrite;
   endsequence

   a_cur_ki_read:
      assert property (s_read(hit_cur) |->
                       prdata[31:16] == $past(active_current_integral_gain))
      else $error("current ki readback wrong");

   a_cur_kp_read:
      assert property (s_read(hit_cur) |->
                       prdata[15:0] == $past(active_current_proportional_gain))
      else $error("current kp readback wrong");

   a_spd_ki_read:
      assert property (s_read(hit_spd) |->
                       prdata[31:16] == $past(active_velocity_integral_gain))
      else $error("speed ki readback wrong");

   a_spd_kp_read:
      assert property (s_read(hit_spd) |->
                       prdata[15:0] == $past(active_velocity_proportional_gain))
      else $error("speed kp readback wrong");

   a_ptr_write:
      assert property (s_write(hit_mon) |=>
                       monitor_one_variable_pointer == 12'($past(pwdata)))
      else $error("variable pointer not written");

   a_frac_unity:
      assert property (frac_n == 4'h8 && single_sided && !monitor_var_value[15]
                       |=> monitor_output_one == 12'($past(monitor_var_value) >>> 3))
      else $error("unity fraction scaling wrong");

   a_frac_div8:
      assert property (frac_n == 4'h1 && single_sided && monitor_var_value == 16'sh4000
                       |=> monitor_output_one == 12'h100)
      else $error("fraction divisor is not eight");

   a_enum_full:
      assert property (frac_n == 4'h0 && pow_p == 4'h0 && single_sided
                       && monitor_var_value == 16'sh1f
                       |=> monitor_output_one == CLMON_CODE_MAX)
      else $error("enum max does not reach top");

   a_pow2_scale:
      assert property (frac_n == 4'h0 && pow_p == 4'h1 && single_sided
                       && monitor_var_value == 16'sh10
                       |=> monitor_output_one == CLMON_CODE_MAX)
      else $error("power of two scaling missing");

   a_bipolar_mid:
      assert property (frac_n == 4'h8 && !single_sided && monitor_var_value == 16'sh0
                       |=> monitor_output_one == CLMON_CODE_MID)
      else $error("bipolar zero not at midscale");

   a_unipolar_neg:
      assert property (frac_n != 4'h0 && single_sided && monitor_var_value[15]
                       |=> monitor_output_one == 12'h000)
      else $error("unipolar negative not at bottom");

   a_rsvd_zero:
      assert property (s_read(hit_mon) |-> prdata[31:21] == 11'h0)
      else $error("reserved bits not zero");

   a_ro_keep:
      assert property (s_write(hit_cur || hit_spd) |=> $stable(st_reg.ctrl))
      else $error("write to gain word changed control");

   // the whole control word lands on a monitor write
   a_ctrl_write:
      assert property (s_write(hit_mon) |=> st_reg.ctrl == 21'($past(pwdata)))
      else $error("control word not written");

   // control word only moves on a monitor write access
   a_ctrl_hold:
      assert property (!(access_ph && pwrite && hit_mon) |=> $stable(st_reg.ctrl))
      else $error("control word changed without a write");

   // pointer reads back in the low bits of the control word
   a_ptr_read:
      assert property (s_read(hit_mon) |->
                       prdata[11:0] == $past(monitor_one_variable_pointer))
      else $error("variable pointer readback wrong");

   // gain word writes are dropped quietly, with no error
   a_gain_no_err:
      assert property (access_ph && pwrite && (hit_cur || hit_spd) |-> !pslverr)
      else $error("gain word write flagged an error");

   // unmapped read gives zero data and an error
   a_unmapped_zero:
      assert property (s_read(!(hit_cur || hit_spd || hit_mon)) |->
                       prdata == 32'h0 && pslverr)
      else $error("unmapped read not refused");

   // mapped words never answer with an error
   a_mapped_ok:
      assert property (access_ph && (hit_cur || hit_spd || hit_mon) |-> !pslverr)
      else $error("mapped access flagged an error");

   // read data stands until the next read setup
   a_rdata_hold:
      assert property (!(setup_ph && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read");

   // largest fraction 15/8 on an eighth-scale value
   a_frac_max:
      assert property (frac_n == 4'hf && single_sided && monitor_var_value == 16'sh1000
                       |=> monitor_output_one == 12'h3c0)
      else $error("fraction fifteen eighths wrong");

   // half scale fraction on a quarter-scale value
   a_frac_half:
      assert property (frac_n == 4'h4 && single_sided && monitor_var_value == 16'sh2000
                       |=> monitor_output_one == 12'h200)
      else $error("fraction four eighths wrong");

   // negative full scale at half fraction lands at a quarter code
   a_frac_neg_bip:
      assert property (frac_n == 4'h4 && !single_sided && monitor_var_value == 16'sh8000
                       |=> monitor_output_one == 12'h400)
      else $error("bipolar half fraction wrong");

   // minus one per-unit sits at the bottom in bipolar mode
   a_bipolar_low:
      assert property (frac_n == 4'h8 && !single_sided && monitor_var_value == 16'sh8000
                       |=> monitor_output_one == 12'h000)
      else $error("bipolar bottom wrong");

   // plus one per-unit sits at the top in bipolar mode
   a_bipolar_high:
      assert property (frac_n == 4'h8 && !single_sided && monitor_var_value == 16'sh7fff
                       |=> monitor_output_one == CLMON_CODE_MAX)
      else $error("bipolar top wrong");

   // zero per-unit sits at the bottom in unipolar mode
   a_unipolar_zero:
      assert property (frac_n != 4'h0 && single_sided && monitor_var_value == 16'sh0
                       |=> monitor_output_one == 12'h000)
      else $error("unipolar zero not at bottom");

   // scaled value above one per-unit saturates at the top
   a_unipolar_sat:
      assert property (frac_n == 4'hf && single_sided && monitor_var_value == 16'sh7fff
                       |=> monitor_output_one == CLMON_CODE_MAX)
      else $error("unipolar overrange not saturated");

   // negative enumeration clamps to the lowest code
   a_enum_clamp:
      assert property (frac_n == 4'h0 && single_sided && monitor_var_value[15]
                       |=> monitor_output_one == 12'h000)
      else $error("negative enum not clamped");

   // enumeration zero sits at midscale in bipolar mode
   a_enum_bipolar:
      assert property (frac_n == 4'h0 && !single_sided && monitor_var_value == 16'sh0
                       |=> monitor_output_one == CLMON_CODE_MID)
      else $error("bipolar enum zero not at midscale");

   // enumeration 31 reaches the top in bipolar mode too
   a_enum_top_bip:
      assert property (frac_n == 4'h0 && pow_p == 4'h0 && !single_sided
                       && monitor_var_value == 16'sh1f
                       |=> monitor_output_one == CLMON_CODE_MAX)
      else $error("bipolar enum max not at top");

   // power field four on value one gives sixteen of 31
   a_pow2_mid:
      assert property (frac_n == 4'h0 && pow_p == 4'h4 && single_sided
                       && monitor_var_value == 16'sh1
                       |=> monitor_output_one == 12'h842)
      else $error("power of two mid scaling wrong");

   // power field has no effect while a fraction is set
   a_pow2_ignored:
      assert property (frac_n == 4'h8 && pow_p == 4'hf && single_sided
                       && monitor_var_value == 16'sh10
                       |=> monitor_output_one == 12'h002)
      else $error("power field applied with fraction set");

endmodule : clmon_regs

`default_nettype wire

// ### bench/clmon_regs_bench.sv
// self-checking bench for the loop gain readback and monitor register bank
`default_nettype none

module clmon_regs_bench import clmon_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]        paddr, ptr, code;
   logic [31:0]        pwdata, prdata;
   logic [15:0]        ki_cur, kp_cur, ki_spd, kp_spd;
   logic signed [15:0] var_val;
   logic [32:0]        rd_q[$];
   logic [11:0]        code_q[$];
   int                 fail_count, n_compared, cycles, seed;

   // directed scaling corners: {control word, monitored value}
   localparam logic [36:0] CORNER [15] = '{
      {21'h030a5, 16'h4000}, {21'h0105a, 16'h001f}, {21'h21000, 16'h0010},
      {21'h10000, 16'h8000}, {21'h10000, 16'h7fff}, {21'h1f000, 16'h1000},
      {21'h81000, 16'h0001}, {21'h01000, 16'hffff}, {21'h00000, 16'h0000},
      {21'h00000, 16'h001f}, {21'h07000, 16'h0000}, {21'h09000, 16'h2000},
      {21'h1f000, 16'h7fff}, {21'h1f1000, 16'h0010}, {21'h08000, 16'h8000}};

   clmon_regs i_clmon_regs (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .active_current_integral_gain(ki_cur), .active_current_proportional_gain(kp_cur),
      .active_velocity_integral_gain(ki_spd), .active_velocity_proportional_gain(kp_spd),
      .monitor_one_variable_pointer(ptr), .monitor_var_value(var_val),
      .monitor_output_one(code));

   // 25 mhz clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bus

   task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_out

   // one apb transfer; a read notes {pslverr, prdata} expected, idle cycle after
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      if (!wr) rd_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // expected output code from control word and monitored q15 value
   function automatic logic [11:0] code_of(input logic [20:0] c, input logic signed [15:0] v);
      int s;
      int l;
      s = v;
      if (c[16:13] != 4'h0) s = (s * int'(c[16:13])) >>> 3;
      else begin
         s = s <<< c[20:17];
         s = (s < 0) ? 0 : (s > 31) ? 31 : s;
         s = s * 32768 / 31;
      end
      l = c[12] ? s : (s + 32768) >>> 1;
      code_of = (l < 0) ? 12'h000 : (l >= 32768) ? 12'hfff : 12'(l >>> 3);
   endfunction : code_of

   // hang guard and bus read checker
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
      if ((psel & penable & pready & ~pwrite) === 1'b1) begin
         chk_bus({pslverr, prdata}, rd_q.pop_front());
      end
   end

   // monitor code checker, sampled mid-cycle where the output is settled
   always @(negedge pclk) begin
      if (code_q.size() > 0) chk_out(code, code_q.pop_front());
   end

   initial begin
      logic [31:0] c;
      logic [31:0] gc;
      logic [31:0] gs;
      logic [15:0] v;
      seed = 32'he2fb;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ki_cur, kp_cur, ki_spd, kp_spd, var_val} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_out(ptr, 12'h000);
      code_q.push_back(12'h800);
      apb(1'b0, CLMON_MON_ADDR, 32'h0, {1'b0, 32'h0011_0000});
      $display("reset values test done");
      // gains follow the inputs; writes to the gain words are dropped
      repeat (2) begin
         gc = $random(seed);
         gs = $random(seed);
         {ki_cur, kp_cur} <= gc;
         {ki_spd, kp_spd} <= gs;
         apb(1'b0, CLMON_CUR_ADDR, 32'h0, {1'b0, gc});
         apb(1'b0, CLMON_SPD_ADDR, 32'h0, {1'b0, gs});
         apb(1'b1, CLMON_CUR_ADDR, ~gc, 33'h0);
         apb(1'b1, CLMON_SPD_ADDR, ~gs, 33'h0);
         apb(1'b0, CLMON_CUR_ADDR, 32'h0, {1'b0, gc});
         apb(1'b0, CLMON_SPD_ADDR, 32'h0, {1'b0, gs});
      end
      apb(1'b0, 12'h3d4, 32'h0, {1'b1, 32'h0});
      apb(1'b1, CLMON_MON_ADDR, 32'hffff_ffff, 33'h0);
      apb(1'b0, CLMON_MON_ADDR, 32'h0, {1'b0, 32'h001f_ffff});
      chk_out(ptr, 12'hfff);
      $display("gain and reserved bits test done");
      // every fraction code in both polarities, random power and pointer
      for (int n = 0; n < 32; n++) begin
         c = $random(seed);
         c[16:13] = n[3:0];
         c[12] = n[4];
         apb(1'b1, CLMON_MON_ADDR, c, 33'h0);
         chk_out(ptr, c[11:0]);
         apb(1'b0, CLMON_MON_ADDR, 32'h0, {12'h0, c[20:0]});
         for (int k = 0; k < 3; k++) begin
            v = $random(seed);
            if (k == 1) v = {11'h0, v[4:0]};
            if (k == 2) v = c[21] ? 16'h8000 : 16'h7fff;
            var_val <= v;
            repeat (2) @(posedge pclk);
            code_q.push_back(code_of(c[20:0], v));
         end
      end
      // directed corners, so each scaling assertion other than a_bipolar_mid and a_unipolar_neg meets its case
      for (int i = 0; i < 15; i++) begin
         apb(1'b1, CLMON_MON_ADDR, {11'h0, CORNER[i][36:16]}, 33'h0);
         var_val <= CORNER[i][15:0];
         repeat (2) @(posedge pclk);
         code_q.push_back(code_of(CORNER[i][36:16], CORNER[i][15:0]));
      end
      @(posedge pclk);
      $display("monitor scaling test done");
      close_out();
   end
endmodule : clmon_regs_bench

`default_nettype wire
